// File: hw/pegpio_pkg.sv
// Purpose: Shared constants and types for the port E pin block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: Register contents are 8 bits wide in the low byte of each word
package pegpio_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_BIDIR = 3;
    localparam int REG_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PIN_INPUT = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_DIRECTION = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ANALOG_CFG = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PIN_STATUS = 8'h10;

    // Field positions
    localparam int INPUT_ONLY_BIT = 3;
    localparam int ASEL_LSB = 0;
    localparam int ASEL_W = 4;
    localparam int REF_LO_BIT = 4;
    localparam int REF_HI_BIT = 5;
    localparam int STAT_RST_EN_BIT = 0;
    localparam int STAT_HV_BIT = 1;
    localparam int STAT_REDUCED_BIT = 2;

    // Reset values: analog selected on all three bidir pins
    localparam logic [NUM_BIDIR-1:0] LATCH_RST = 3'h0;
    localparam logic [NUM_BIDIR-1:0] DIR_RST = 3'h0;
    localparam logic [REG_W-1:0] ANALOG_CFG_RST = 8'h00;
    localparam logic [REG_W-1:0] ANALOG_CFG_MASK = 8'h3f;

    // Pin i (channel 5+i) is analog while the select field is below its limit
    localparam logic [ASEL_W-1:0] ASEL_LIMIT_0 = 4'ha;
    localparam logic [ASEL_W-1:0] ASEL_LIMIT_1 = 4'h9;
    localparam logic [ASEL_W-1:0] ASEL_LIMIT_2 = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [REG_W-1:0] analog_cfg;
        logic [NUM_BIDIR-1:0] dir;
        logic [NUM_BIDIR-1:0] latch;
    } pegpio_regs_type;

    typedef struct packed {
        logic hv_detect;
        logic rst_en;
        logic input_only;
        logic [NUM_BIDIR-1:0] bidir;
    } pegpio_pins_type;
endpackage : pegpio_pkg

// File: hw/pegpio_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to ref_clk
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ns
module pegpio_pin_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;

    always_comb begin
        out_d = sync_out;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sync_out <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_out <= out_d;
        end
    end
endmodule : pegpio_pin_sync

// File: hw/pegpio_top.sv
// Purpose: Port E pin logic with AXI4-Lite register access
// Assumes: Pins synchronised on ref_clk; pad resolves pin from out and oe_n
// Notes: REDUCED_PINS selects the variant with the input-only pin alone
//
// Summary of operation
// R1: Input-only pin is a pure digital input, no direction or latch bit.
// R2: Shared pin acts as external reset input when reset enable is set.
// R3: After reset, input-only pin is digital only with reset function disabled.
// R4: Reduced variant has a port only with reset disabled, input pin alone.
// R5: Pin input bits 7 to 4 always read zero.
// R6: Pin input bits 3 to 0 show the four pin levels.
// R7: Pin input bit 3 reads zero while reset function is enabled.
// R8: Reduced variant reads pin input bits 2 to 0 as zero.
// R9: Direction bit 0 drives latch onto the pin, analog or not.
// R10: Direction 1 feeds pin to input bit, blocked while analog selected.
// R11: After reset the three bidir pins are analog channels 5, 6, 7.
// R12: High-voltage detection on the shared pin works in every mode.
// R13: Latch and direction bits 7 to 3 read zero.
// R14: Reduced variant has no latch or direction register.
// R15: Direction 1 makes pin input, high impedance; 0 drives latch value.
// R16: A bidir pin in analog mode reads zero.
// R17: Direction bits still steer the pin while it is analog.
// R18: Latch reads return latch contents, not pin levels.
// R19: Writing the pin input address writes latch bits 2 to 0.
// R20: Reset clears latch and direction; input-only bit follows its pin.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module pegpio_top #(
    parameter bit REDUCED_PINS = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [pegpio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pegpio_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pegpio_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pegpio_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [pegpio_pkg::NUM_BIDIR-1:0] bidir_pin_in,
    output logic [pegpio_pkg::NUM_BIDIR-1:0] bidir_pin_out,
    output logic [pegpio_pkg::NUM_BIDIR-1:0] bidir_pin_oe_n,
    input wire logic input_only_pin_in,
    input wire logic reset_pin_enable_cfg,
    input wire logic hv_detect_in,
    output logic [pegpio_pkg::NUM_BIDIR-1:0] analog_channel_en,
    output logic external_reset_req,
    output logic prog_voltage_detect
);
    pegpio_pkg::pegpio_regs_type regs_q;
    pegpio_pkg::pegpio_regs_type regs_d;
    pegpio_pkg::pegpio_pins_type pins_s;
    logic [pegpio_pkg::NUM_BIDIR-1:0] analog_sel;
    logic [pegpio_pkg::REG_W-1:0] pin_input_val;
    logic [pegpio_pkg::REG_W-1:0] latch_val;
    logic [pegpio_pkg::REG_W-1:0] dir_val;
    logic [pegpio_pkg::REG_W-1:0] status_val;
    logic [pegpio_pkg::ASEL_W-1:0] asel;

    // Bus handshake state
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [pegpio_pkg::DATA_W-1:0] rdata_d;
    logic [pegpio_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [pegpio_pkg::REG_W-1:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic do_wr;

    // Pin outputs
    logic [pegpio_pkg::NUM_BIDIR-1:0] pin_out_d, pin_oe_n_d, analog_en_d;
    logic ext_rst_d;

    pegpio_pin_sync #(
        .W(6)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in({hv_detect_in, reset_pin_enable_cfg, input_only_pin_in, bidir_pin_in}),
        .sync_out(pins_s)
    );

    // Analog selection per pin from the select field
    always_comb begin
        asel = regs_q.analog_cfg[pegpio_pkg::ASEL_LSB +: pegpio_pkg::ASEL_W];
        analog_sel[0] = asel < pegpio_pkg::ASEL_LIMIT_0; // R11
        analog_sel[1] = asel < pegpio_pkg::ASEL_LIMIT_1; // R11
        analog_sel[2] = asel < pegpio_pkg::ASEL_LIMIT_2; // R11
    end

    // Read views of the registers
    always_comb begin
        pin_input_val = '0; // R5
        if (!pins_s.rst_en) begin
            pin_input_val[pegpio_pkg::INPUT_ONLY_BIT] = pins_s.input_only; // R1 R6 R7 R20
        end
        latch_val = '0; // R13
        dir_val = '0; // R13
        if (!REDUCED_PINS) begin
            // Level read whatever the direction; analog pins read zero
            pin_input_val[pegpio_pkg::NUM_BIDIR-1:0] = pins_s.bidir & ~analog_sel; // R6 R8 R10 R16
            latch_val[pegpio_pkg::NUM_BIDIR-1:0] = regs_q.latch; // R18
            dir_val[pegpio_pkg::NUM_BIDIR-1:0] = regs_q.dir;
        end
        status_val = '0;
        status_val[pegpio_pkg::STAT_RST_EN_BIT] = pins_s.rst_en;
        status_val[pegpio_pkg::STAT_HV_BIT] = pins_s.hv_detect;
        status_val[pegpio_pkg::STAT_REDUCED_BIT] = REDUCED_PINS;
    end

    // Write channel: address and data taken in either order
    always_comb begin
        do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        regs_d = regs_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            wbyte_d = s_axi_wdata[pegpio_pkg::REG_W-1:0];
            wlane_d = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = pegpio_pkg::RESP_OKAY;
            unique case (awaddr_q)
                pegpio_pkg::OFF_PIN_INPUT, pegpio_pkg::OFF_OUTPUT_LATCH: begin
                    // Reduced variant has no latch: write is accepted and dropped
                    if (wlane_q && !REDUCED_PINS) begin
                        regs_d.latch = wbyte_q[pegpio_pkg::NUM_BIDIR-1:0]; // R19 R14
                    end
                end
                pegpio_pkg::OFF_DIRECTION: begin
                    if (wlane_q && !REDUCED_PINS) begin
                        regs_d.dir = wbyte_q[pegpio_pkg::NUM_BIDIR-1:0]; // R15 R14
                    end
                end
                pegpio_pkg::OFF_ANALOG_CFG: begin
                    if (wlane_q) begin
                        regs_d.analog_cfg = wbyte_q & pegpio_pkg::ANALOG_CFG_MASK;
                    end
                end
                pegpio_pkg::OFF_PIN_STATUS: begin
                end
                default: begin
                    bresp_d = pegpio_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_full_d;
        wready_d = !w_full_d;
    end

    // Read channel: one cycle from address to data
    always_comb begin
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = pegpio_pkg::RESP_OKAY;
            rdata_d = '0;
            unique case (s_axi_araddr)
                pegpio_pkg::OFF_PIN_INPUT: rdata_d[pegpio_pkg::REG_W-1:0] = pin_input_val;
                pegpio_pkg::OFF_OUTPUT_LATCH: rdata_d[pegpio_pkg::REG_W-1:0] = latch_val;
                pegpio_pkg::OFF_DIRECTION: rdata_d[pegpio_pkg::REG_W-1:0] = dir_val;
                pegpio_pkg::OFF_ANALOG_CFG: rdata_d[pegpio_pkg::REG_W-1:0] = regs_q.analog_cfg;
                pegpio_pkg::OFF_PIN_STATUS: rdata_d[pegpio_pkg::REG_W-1:0] = status_val;
                default: rresp_d = pegpio_pkg::RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    // Pad and mux outputs
    always_comb begin
        if (REDUCED_PINS) begin
            pin_out_d = '0;
            pin_oe_n_d = '1; // R4 R14
            analog_en_d = '0;
        end else begin
            // Direction steers the pad even in analog mode
            pin_out_d = regs_q.latch; // R9
            pin_oe_n_d = regs_q.dir; // R9 R15 R17
            analog_en_d = analog_sel; // R11
        end
        // Pin is active low reset when enabled
        ext_rst_d = pins_s.rst_en && !pins_s.input_only; // R2 R3
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regs_q.latch <= pegpio_pkg::LATCH_RST; // R20
            regs_q.dir <= pegpio_pkg::DIR_RST; // R20
            regs_q.analog_cfg <= pegpio_pkg::ANALOG_CFG_RST; // R11
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pegpio_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= pegpio_pkg::RESP_OKAY;
            bidir_pin_out <= '0;
            bidir_pin_oe_n <= '1;
            analog_channel_en <= '0;
            external_reset_req <= 1'b0;
            prog_voltage_detect <= 1'b0;
        end else begin
            regs_q <= regs_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            bidir_pin_out <= pin_out_d;
            bidir_pin_oe_n <= pin_oe_n_d;
            analog_channel_en <= analog_en_d;
            external_reset_req <= ext_rst_d;
            prog_voltage_detect <= pins_s.hv_detect; // R12
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_pad_follows_regs: assert property ( // R9
        !REDUCED_PINS |=> bidir_pin_out == $past(regs_q.latch)
            && bidir_pin_oe_n == $past(regs_q.dir))
        else $error("pad does not follow latch and direction");

    a_reduced_no_drive: assert property ( // R14
        REDUCED_PINS |-> bidir_pin_oe_n == '1 && dir_val == '0 && latch_val == '0)
        else $error("reduced variant drives or holds latch");

    // Data rises one edge after the address is taken, so that address is one edge back
    a_upper_zero: assert property ( // R5
        $rose(s_axi_rvalid) && $past(s_axi_araddr) == pegpio_pkg::OFF_PIN_INPUT
            |-> s_axi_rdata[pegpio_pkg::DATA_W-1:pegpio_pkg::REG_W-4] == '0)
        else $error("pin input upper bits not zero");

    a_bit3_gated: assert property ( // R7
        $rose(s_axi_rvalid) && $past(s_axi_araddr) == pegpio_pkg::OFF_PIN_INPUT
            && $past(pins_s.rst_en) |-> !s_axi_rdata[pegpio_pkg::INPUT_ONLY_BIT])
        else $error("input-only bit visible with reset enabled");

    a_analog_zero: assert property ( // R16
        $rose(s_axi_rvalid) && $past(s_axi_araddr) == pegpio_pkg::OFF_PIN_INPUT
            |-> (s_axi_rdata[pegpio_pkg::NUM_BIDIR-1:0] & $past(analog_sel)) == '0)
        else $error("analog pin reads nonzero");

    a_reset_request: assert property ( // R2
        pins_s.rst_en && !pins_s.input_only |=> external_reset_req)
        else $error("reset request missing");

    a_hv_always: assert property ( // R12
        $changed(pins_s.hv_detect) |=> prog_voltage_detect == $past(pins_s.hv_detect))
        else $error("voltage detect not passed on");

    a_input_write: assert property ( // R19
        do_wr && wlane_q && !REDUCED_PINS && awaddr_q == pegpio_pkg::OFF_PIN_INPUT
            |=> regs_q.latch == $past(wbyte_q[pegpio_pkg::NUM_BIDIR-1:0]))
        else $error("input address write missed latch");

    a_read_latch: assert property ( // R18
        s_axi_arvalid && s_axi_arready && s_axi_araddr == pegpio_pkg::OFF_OUTPUT_LATCH
            |=> s_axi_rvalid && s_axi_rdata[pegpio_pkg::REG_W-1:0] == $past(latch_val))
        else $error("latch read wrong");

    a_write_resp: assert property (
        s_axi_awvalid && s_axi_awready ##0 (!s_axi_bvalid)[*1] ##1 w_full_q && aw_full_q
            |=> s_axi_bvalid)
        else $error("write response late");

    c_write_latch: cover property (do_wr && awaddr_q == pegpio_pkg::OFF_OUTPUT_LATCH);
    c_read_input: cover property (s_axi_rvalid && s_axi_rready);
    c_digital_pin: cover property (!analog_sel[0] && pin_input_val[0]);
    c_reset_req: cover property ($rose(external_reset_req));
endmodule : pegpio_top

// File: dv/pegpio_pin_model.sv
// Purpose: Pad model resolving the three bidir pins seen by the port
// Assumes: Far-side source always drives a defined level when the port lets go
// Notes: No pull devices modelled; the source level stands in for the pad
`timescale 1ns/1ns
module pegpio_pin_model (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [2:0] ext_level,
    output logic [2:0] pad
);
    // Port driver wins wherever its enable is low; otherwise the source
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
endmodule : pegpio_pin_model

// File: dv/pegpio_top_tb_top.sv
// Purpose: Self-checking bench for the port E pin block
// Assumes: Full and reduced variants side by side; pins settle within eight cycles
// Notes: Reads and responses are queued as notes and matched by a monitor
`timescale 1ns/1ns
module pegpio_top_tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] bidir_pin_in, bidir_pin_out, bidir_pin_oe_n, analog_channel_en;
    logic [2:0] ext = 3'h0;
    logic input_only_pin_in = 1'b0;
    logic reset_pin_enable_cfg = 1'b0;
    logic hv_detect_in = 1'b0;
    logic external_reset_req, prog_voltage_detect;
    logic [2:0] lat, dir;
    logic [7:0] cfg;
    logic [33:0] rq[$];
    logic [33:0] rrq[$];
    logic [31:0] r_rdata;
    logic [1:0] r_rresp;
    logic r_rvalid;
    logic [2:0] r_oe_n, r_an;
    logic [1:0] bq[$];
    int n_errors = 0;
    int checked = 0;

    pegpio_top dut_u (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bidir_pin_in,
        .bidir_pin_out, .bidir_pin_oe_n, .input_only_pin_in, .reset_pin_enable_cfg,
        .hv_detect_in, .analog_channel_en, .external_reset_req, .prog_voltage_detect);
    pegpio_pin_model pad_u (.pin_out(bidir_pin_out), .pin_oe_n(bidir_pin_oe_n),
        .ext_level(ext), .pad(bidir_pin_in));

    // Reduced variant shares bus and pins; same handshake timing, only data differs
    pegpio_top #(.REDUCED_PINS(1'b1)) dut_reduced_u (.ref_clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(r_rdata), .s_axi_rresp(r_rresp),
        .s_axi_rvalid(r_rvalid), .s_axi_rready, .bidir_pin_in, .bidir_pin_out(),
        .bidir_pin_oe_n(r_oe_n), .input_only_pin_in, .reset_pin_enable_cfg, .hv_detect_in,
        .analog_channel_en(r_an), .external_reset_req(), .prog_voltage_detect());

    always #5 ref_clk = ~ref_clk;

    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        bit aw;
        bit w;
        aw = 1'b0;
        w = 1'b0;
        bq.push_back(r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge ref_clk);
            aw = aw | (s_axi_awvalid & s_axi_awready);
            w = w | (s_axi_wvalid & s_axi_wready);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        rq.push_back({r, 24'h0, d});
        // Reduced: no latch or direction, bidir input bits zero, status flags the variant
        rrq.push_back({r, 24'h0, (a == pegpio_pkg::OFF_OUTPUT_LATCH) ? 8'h00 :
            (a == pegpio_pkg::OFF_DIRECTION) ? 8'h00 :
            (a == pegpio_pkg::OFF_PIN_INPUT) ? (d & 8'h08) :
            (a == pegpio_pkg::OFF_PIN_STATUS) ? (d | 8'h04) : d});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Expected input register from pad levels, analog selection and reset mode
    function automatic logic [7:0] pin_exp();
        logic [2:0] pad;
        logic [7:0] e;
        pad = (dir & ext) | (~dir & lat);
        e = 8'h00;
        for (int i = 0; i < 3; i++) e[i] = (cfg[3:0] < 4'(10 - i)) ? 1'b0 : pad[i];
        e[3] = reset_pin_enable_cfg ? 1'b0 : input_only_pin_in;
        return e;
    endfunction : pin_exp

    function automatic logic [2:0] an_exp();
        for (int i = 0; i < 3; i++) an_exp[i] = cfg[3:0] < 4'(10 - i);
    endfunction : an_exp

    always @(posedge ref_clk) begin
        if (s_axi_bvalid && s_axi_bready) check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (r_rvalid && s_axi_rready) begin
            check("rdata_reduced", {r_rresp, r_rdata}, rrq.pop_front());
        end
    end

    // Whole run is under a thousand cycles; this is a hang guard only
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(32'hce2fee39));
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("pin_oe_n", {31'h0, bidir_pin_oe_n}, 34'h0);
        check("analog_en", {31'h0, analog_channel_en}, 34'h7);
        rd(pegpio_pkg::OFF_OUTPUT_LATCH, 8'h00, pegpio_pkg::RESP_OKAY);
        rd(pegpio_pkg::OFF_DIRECTION, 8'h00, pegpio_pkg::RESP_OKAY);
        rd(pegpio_pkg::OFF_ANALOG_CFG, 8'h00, pegpio_pkg::RESP_OKAY);
        for (int i = 0; i < 20; i++) begin
            lat = 3'($urandom);
            dir = 3'($urandom);
            cfg = {4'($urandom), 4'(i)};
            // Odd passes write the latch through the input register address
            wr(i[0] ? pegpio_pkg::OFF_PIN_INPUT : pegpio_pkg::OFF_OUTPUT_LATCH, {5'h1f, lat}, pegpio_pkg::RESP_OKAY);
            wr(pegpio_pkg::OFF_DIRECTION, {5'h1f, dir}, pegpio_pkg::RESP_OKAY);
            wr(pegpio_pkg::OFF_ANALOG_CFG, cfg, pegpio_pkg::RESP_OKAY);
            ext <= 3'($urandom);
            input_only_pin_in <= 1'($urandom);
            reset_pin_enable_cfg <= 1'($urandom);
            hv_detect_in <= 1'($urandom);
            repeat (8) @(posedge ref_clk);
            check("pin_out", {31'h0, bidir_pin_out}, {31'h0, lat});
            check("pin_oe_n", {31'h0, bidir_pin_oe_n}, {31'h0, dir});
            check("analog_en", {31'h0, analog_channel_en}, {31'h0, an_exp()});
            check("ext_reset", {33'h0, external_reset_req}, {33'h0, reset_pin_enable_cfg & ~input_only_pin_in});
            check("hv_detect", {33'h0, prog_voltage_detect}, {33'h0, hv_detect_in});
            check("reduced_pads", {28'h0, r_oe_n, r_an}, {28'h0, 3'h7, 3'h0});
            rd(pegpio_pkg::OFF_OUTPUT_LATCH, {5'h0, lat}, pegpio_pkg::RESP_OKAY);
            rd(pegpio_pkg::OFF_DIRECTION, {5'h0, dir}, pegpio_pkg::RESP_OKAY);
            rd(pegpio_pkg::OFF_ANALOG_CFG, cfg & 8'h3f, pegpio_pkg::RESP_OKAY);
            rd(pegpio_pkg::OFF_PIN_INPUT, pin_exp(), pegpio_pkg::RESP_OKAY);
            rd(pegpio_pkg::OFF_PIN_STATUS, {6'h0, hv_detect_in, reset_pin_enable_cfg}, pegpio_pkg::RESP_OKAY);
        end
        // Unmapped place: refused and leaves the latch alone
        wr(8'h20, 8'hff, pegpio_pkg::RESP_SLVERR);
        rd(8'h20, 8'h00, pegpio_pkg::RESP_SLVERR);
        rd(pegpio_pkg::OFF_OUTPUT_LATCH, {5'h0, lat}, pegpio_pkg::RESP_OKAY);
        repeat (4) @(posedge ref_clk);
        stop_test();
    end
endmodule : pegpio_top_tb_top
